// ### drive_link_pkg.sv
// Shared constants, codes and state type for the drive link sequencer.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
package drive_link_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 200_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
  localparam int GAP_MS        = 15;
  localparam int GAP_CNT_W     = 5;
  // One extra tick covers the partial first millisecond of a free tick.
  localparam logic [GAP_CNT_W-1:0] GAP_TICKS = GAP_CNT_W'(GAP_MS + 1);

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int DEF_SLOTS = 8;
  localparam int KIND_W    = 3;
  localparam int STEP_W    = 16;
  localparam int CODE_W    = 16;

  // ---------------------------------------------------------------------
  // Request kinds
  // ---------------------------------------------------------------------
  localparam logic [KIND_W-1:0] KIND_MONITOR     = 3'h0;
  localparam logic [KIND_W-1:0] KIND_CONTROL     = 3'h1;
  localparam logic [KIND_W-1:0] KIND_PARAM_READ  = 3'h2;
  localparam logic [KIND_W-1:0] KIND_PARAM_WRITE = 3'h3;
  localparam logic [KIND_W-1:0] KIND_BATCH_WRITE = 3'h4;

  // ---------------------------------------------------------------------
  // Fault codes (decimal 6301, 3801, 6320, 3820) and reset values
  // ---------------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_SERIAL_CH1 = 16'h189d;
  localparam logic [CODE_W-1:0] CODE_SERIAL_CH2 = 16'h0ed9;
  localparam logic [CODE_W-1:0] CODE_DRIVE_CH1  = 16'h18b0;
  localparam logic [CODE_W-1:0] CODE_DRIVE_CH2  = 16'h0eec;
  localparam logic [CODE_W-1:0] CODE_RESET      = 16'h0000;
  localparam logic [STEP_W-1:0] STEP_RESET      = 16'h0000;

  // ---------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_XFER,
    ST_HALT,
    ST_GAP
  } seq_state_t;

endpackage : drive_link_pkg

// ### ms_tick_gen.sv
// Free-running divider giving a one-cycle pulse once per millisecond.
// Assumes the system clock; CYCLES may be shortened for simulation.
module ms_tick_gen
  import drive_link_pkg::*;
#(
  parameter int unsigned CYCLES = CYCLES_PER_MS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tick;

  // Counter wraps at CYCLES-1 and flags the wrap.
  always_comb begin
    next_tick  = (count == W'(CYCLES - 1));
    next_count = next_tick ? '0 : count + W'(1);
  end

  // Registers of the divider.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      count  <= next_count;
      o_tick <= next_tick;
    end
  end

endmodule : ms_tick_gen

// ### req_order_arbiter.sv
// Picks the next pending request slot after the last served one.
// Assumes slot order equals program order; purely combinational.
module req_order_arbiter #(
  parameter int SLOTS = 8,
  parameter int IDX_W = 3
) (
  input  wire logic [SLOTS-1:0] i_pend,
  input  wire logic [IDX_W-1:0] i_last,
  output logic                  o_valid,
  output logic [IDX_W-1:0]      o_idx
);

  // Walk backwards so the slot nearest after i_last is kept.
  always_comb begin
    int pos;
    pos     = 0;
    o_valid = 1'b0;
    o_idx   = i_last;
    for (int k = SLOTS; k >= 1; k--) begin
      pos = (int'(i_last) + k) % SLOTS;
      if (i_pend[pos]) begin
        o_valid = 1'b1;
        o_idx   = IDX_W'(pos);
      end
    end
  end

endmodule : req_order_arbiter

// ### drive_link_request_sequencer.sv
// Sequencer for drive requests on one serial channel.
// Assumes a link engine that does the framing and reports each result.
//
// How it works
// - Five request kinds, two reading, three writing.
// - Rising drive starts; drive falling does not end the exchange.
// - Drive held on repeats the request forever.
// - Concurrent requests run singly in program order.
// - New request waits while port busy held.
// - Wait 15 ms after port frees, then next.
// - Pending request dropped if drive off in gap.
// - Completion flag high for exactly one scan.
// - Flags show each request's own result; codes change on errors only.
// - Framing class error: serial flag, serial code only.
// - Other error: both flags, latch, drive code.
// - Drive fault records failing request's step number.
// - Detailed drive fault code word kept per channel.
// - State step off halts exchange, blocks others.
// - State step on again resumes halted exchange.
// - Stop to run reinitialises communication state.
// - Port busy stays on through whole exchange.
// - Completion pulse also given on drive fault.
// - Stop to run clears all fault flags, words.
module drive_link_request_sequencer
  import drive_link_pkg::*;
#(
  parameter int          SLOTS     = DEF_SLOTS,
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS,
  parameter logic        CHANNEL   = 1'b0
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_scan,
  input  wire logic                  i_run,
  input  wire logic [SLOTS-1:0]      i_drive,
  input  wire logic [SLOTS-1:0]      i_state_on,
  input  wire logic [SLOTS*3-1:0]    i_req_kind,
  input  wire logic [SLOTS*16-1:0]   i_req_step,
  input  wire logic                  i_xfer_done,
  input  wire logic                  i_xfer_err_serial,
  input  wire logic                  i_xfer_err_drive,
  input  wire logic [CODE_W-1:0]     i_xfer_err_code,
  input  wire logic                  i_batch_err,
  input  wire logic [CODE_W-1:0]     i_batch_err_param,
  output logic                       o_xfer_start,
  output logic                       o_xfer_halt,
  output logic [KIND_W-1:0]          o_xfer_kind,
  output logic                       o_xfer_to_drive,
  output logic [STEP_W-1:0]          o_exec_step,
  output logic                       o_port_busy,
  output logic                       o_done_pulse_flag,
  output logic                       o_serial_fault,
  output logic [CODE_W-1:0]          o_serial_fault_code,
  output logic                       o_drive_fault,
  output logic                       o_drive_fault_latch,
  output logic [CODE_W-1:0]          o_drive_fault_code,
  output logic [STEP_W-1:0]          o_fault_step,
  output logic                       o_batch_write_fault,
  output logic [CODE_W-1:0]          o_batch_fault_param
);

  localparam int IDX_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;
  localparam logic [IDX_W-1:0] LAST_SLOT = IDX_W'(SLOTS - 1);
  localparam logic [CODE_W-1:0] CODE_SERIAL =
    CHANNEL ? CODE_SERIAL_CH2 : CODE_SERIAL_CH1;
  localparam logic [CODE_W-1:0] CODE_DRIVE =
    CHANNEL ? CODE_DRIVE_CH2 : CODE_DRIVE_CH1;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  seq_state_t           state;
  seq_state_t           next_state;
  logic [IDX_W-1:0]     cur;
  logic [IDX_W-1:0]     next_cur;
  logic [SLOTS-1:0]     pend;
  logic [SLOTS-1:0]     next_pend;
  logic [SLOTS-1:0]     drive_q;
  logic [SLOTS-1:0]     next_drive_q;
  logic [GAP_CNT_W-1:0] gap_cnt;
  logic [GAP_CNT_W-1:0] next_gap_cnt;
  logic                 run_q;
  logic                 done_wait;
  logic                 next_done_wait;
  logic                 next_done;
  logic [KIND_W-1:0]    next_kind;
  logic [STEP_W-1:0]    next_step;
  logic                 next_to_drive;
  logic                 next_serial;
  logic [CODE_W-1:0]    next_serial_code;
  logic                 next_drive_f;
  logic                 next_latch;
  logic [CODE_W-1:0]    next_drive_code;
  logic [STEP_W-1:0]    next_fault_step;
  logic                 next_batch_f;
  logic [CODE_W-1:0]    next_batch_param;

  logic                 ms_tick;
  logic                 grant_valid;
  logic [IDX_W-1:0]     grant_idx;
  logic                 run_rise;
  logic                 finish;
  logic [SLOTS-1:0]     rise;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  ms_tick_gen #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (ms_tick)
  );

  // Search starts just after the slot last served.
  req_order_arbiter #(
    .SLOTS (SLOTS),
    .IDX_W (IDX_W)
  ) u_arb (
    .i_pend  (pend),
    .i_last  (cur),
    .o_valid (grant_valid),
    .o_idx   (grant_idx)
  );

  // Edge and completion terms.
  assign run_rise = i_run & ~run_q;
  assign finish   = (state == ST_XFER) && i_xfer_done;
  assign rise     = i_drive & ~drive_q & {SLOTS{i_scan}};

  // Handshake outputs decoded from the state register.
  assign o_xfer_start = (state == ST_START);
  assign o_xfer_halt  = (state == ST_HALT);
  assign o_port_busy  = (state == ST_START) || (state == ST_XFER) ||
                        (state == ST_HALT);

  // -----------------------------------------------------------------------
  // Sequencing
  // -----------------------------------------------------------------------
  // Pending set, slot choice, exchange progress and post-release gap.
  always_comb begin
    next_state    = state;
    next_cur      = cur;
    next_gap_cnt  = gap_cnt;
    next_kind     = o_xfer_kind;
    next_step     = o_exec_step;
    next_to_drive = o_xfer_to_drive;
    next_drive_q  = i_scan ? i_drive : drive_q;
    next_pend     = pend | rise;
    case (state)
      ST_IDLE: begin
        if (i_run && grant_valid) begin
          next_state          = ST_START;
          next_cur            = grant_idx;
          next_pend[grant_idx] = 1'b0;
          next_kind     = i_req_kind[grant_idx*KIND_W +: KIND_W];
          next_step     = i_req_step[grant_idx*STEP_W +: STEP_W];
          // Monitor and parameter read move data toward us.
          next_to_drive = (next_kind != KIND_MONITOR) &&
                          (next_kind != KIND_PARAM_READ);
        end
      end
      ST_START: begin
        next_state = ST_XFER;
      end
      ST_XFER: begin
        // Drive dropping here does not stop the exchange.
        if (i_xfer_done) begin
          next_state     = ST_GAP;
          next_gap_cnt   = '0;
          next_pend[cur] = next_pend[cur] | i_drive[cur];
        end else if (!i_state_on[cur]) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (i_state_on[cur]) begin
          next_state = ST_XFER;
        end
      end
      ST_GAP: begin
        next_pend = next_pend & i_drive;
        if (ms_tick) begin
          next_gap_cnt = gap_cnt + GAP_CNT_W'(1);
        end
        if (gap_cnt == GAP_TICKS) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Entering run starts the link over from a clean state.
    if (run_rise) begin
      next_state   = ST_IDLE;
      next_cur     = LAST_SLOT;
      next_pend    = '0;
      next_gap_cnt = '0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state           <= ST_IDLE;
      cur             <= LAST_SLOT;
      pend            <= '0;
      drive_q         <= '0;
      gap_cnt         <= '0;
      run_q           <= 1'b0;
      o_xfer_kind     <= KIND_MONITOR;
      o_exec_step     <= STEP_RESET;
      o_xfer_to_drive <= 1'b0;
    end else begin
      state           <= next_state;
      cur             <= next_cur;
      pend            <= next_pend;
      drive_q         <= next_drive_q;
      gap_cnt         <= next_gap_cnt;
      run_q           <= i_run;
      o_xfer_kind     <= next_kind;
      o_exec_step     <= next_step;
      o_xfer_to_drive <= next_to_drive;
    end
  end

  // -----------------------------------------------------------------------
  // Completion and fault reporting
  // -----------------------------------------------------------------------
  // Each finished request replaces the serial, drive and batch flags; codes change on errors only.
  always_comb begin
    next_done        = o_done_pulse_flag;
    next_done_wait   = done_wait | finish;
    next_serial      = o_serial_fault;
    next_serial_code = o_serial_fault_code;
    next_drive_f     = o_drive_fault;
    next_latch       = o_drive_fault_latch;
    next_drive_code  = o_drive_fault_code;
    next_fault_step  = o_fault_step;
    next_batch_f     = o_batch_write_fault;
    next_batch_param = o_batch_fault_param;
    // The flag rises at a scan boundary and falls at the next one.
    if (i_scan) begin
      next_done      = done_wait;
      next_done_wait = finish;
    end
    if (finish) begin
      next_serial  = i_xfer_err_serial | i_xfer_err_drive;
      next_drive_f = i_xfer_err_drive & ~i_xfer_err_serial;
      next_batch_f = (o_xfer_kind == KIND_BATCH_WRITE) & i_batch_err;
      if (i_xfer_err_serial) begin
        next_serial_code = CODE_SERIAL;
      end else if (i_xfer_err_drive) begin
        next_serial_code = CODE_DRIVE;
        next_latch       = 1'b1;
        next_drive_code  = i_xfer_err_code;
        next_fault_step  = o_exec_step;
      end
      if ((o_xfer_kind == KIND_BATCH_WRITE) && i_batch_err) begin
        next_batch_param = i_batch_err_param;
      end
    end
    if (run_rise) begin
      next_done        = 1'b0;
      next_done_wait   = 1'b0;
      next_serial      = 1'b0;
      next_serial_code = CODE_RESET;
      next_drive_f     = 1'b0;
      next_latch       = 1'b0;
      next_drive_code  = CODE_RESET;
      next_fault_step  = STEP_RESET;
      next_batch_f     = 1'b0;
      next_batch_param = CODE_RESET;
    end
  end

  // Result registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_wait           <= 1'b0;
      o_done_pulse_flag   <= 1'b0;
      o_serial_fault      <= 1'b0;
      o_serial_fault_code <= CODE_RESET;
      o_drive_fault       <= 1'b0;
      o_drive_fault_latch <= 1'b0;
      o_drive_fault_code  <= CODE_RESET;
      o_fault_step        <= STEP_RESET;
      o_batch_write_fault <= 1'b0;
      o_batch_fault_param <= CODE_RESET;
    end else begin
      done_wait           <= next_done_wait;
      o_done_pulse_flag   <= next_done;
      o_serial_fault      <= next_serial;
      o_serial_fault_code <= next_serial_code;
      o_drive_fault       <= next_drive_f;
      o_drive_fault_latch <= next_latch;
      o_drive_fault_code  <= next_drive_code;
      o_fault_step        <= next_fault_step;
      o_batch_write_fault <= next_batch_f;
      o_batch_fault_param <= next_batch_param;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_busy_in_xfer: assert property (
    (state == ST_XFER) |-> o_port_busy ##1 (o_port_busy || finish ||
      $past(finish)))
    else $error("port busy dropped during exchange");

  a_start_when_free: assert property (
    o_xfer_start |-> !$past(o_port_busy) && $past(state) == ST_IDLE)
    else $error("request started while port busy");

  a_grant_pending: assert property (
    o_xfer_start |-> $past(pend[next_cur]) ##1 !o_xfer_start)
    else $error("started slot was not pending");

  a_gap_hold: assert property (
    (state == ST_GAP && gap_cnt != GAP_TICKS && !run_rise)
      |=> state == ST_GAP && !o_xfer_start)
    else $error("gap ended early");

  a_gap_drop: assert property (
    (state == ST_GAP) |=> (pend & ~$past(i_drive)) == '0)
    else $error("undriven request kept pending in gap");

  a_done_holds: assert property (
    (o_done_pulse_flag && !i_scan && !run_rise) |=> o_done_pulse_flag)
    else $error("done flag shorter than a scan");

  a_done_ends: assert property (
    (o_done_pulse_flag && i_scan && !done_wait && !finish)
      |=> !o_done_pulse_flag)
    else $error("done flag longer than a scan");

  a_serial_err: assert property (
    (finish && i_xfer_err_serial && !run_rise) |=> o_serial_fault &&
      !o_drive_fault && o_serial_fault_code == CODE_SERIAL)
    else $error("serial error not reported");

  a_drive_err: assert property (
    (finish && i_xfer_err_drive && !i_xfer_err_serial && !run_rise)
      |=> o_drive_fault && o_drive_fault_latch && o_serial_fault &&
      o_serial_fault_code == CODE_DRIVE &&
      o_fault_step == $past(o_exec_step))
    else $error("drive error not reported");

  a_halt_holds: assert property (
    (state == ST_HALT && !i_state_on[cur] && !run_rise)
      |=> state == ST_HALT && o_port_busy && !o_xfer_start)
    else $error("halted exchange did not hold");

  a_run_clears: assert property (
    run_rise |=> !o_serial_fault && !o_drive_fault &&
      !o_drive_fault_latch && state == ST_IDLE)
    else $error("run entry did not clear state");

endmodule : drive_link_request_sequencer

// ### link_engine_model.sv
// Behavioural link engine that answers the sequencer's exchange requests.
// Assumes the bench sets delay, result mode and fault code per request.
module link_engine_model
  import drive_link_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic        i_halt,
  input  wire logic [7:0]  i_delay,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_batch,
  input  wire logic [15:0] i_code,
  output logic             o_done,
  output logic             o_err_serial,
  output logic             o_err_drive,
  output logic [15:0]      o_err_code,
  output logic             o_batch_err,
  output logic [15:0]      o_batch_param
);
  logic [7:0]  cnt;
  logic        busy;
  logic [15:0] junk;

  // Counts down the exchange and pauses while halted; this engine is the
  // only user of the channel, no generic transfer shares it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt    <= 8'h00;
      busy   <= 1'b0;
      o_done <= 1'b0;
      junk   <= 16'h0000;
    end else begin
      junk   <= junk + 16'h1357;
      o_done <= 1'b0;
      if (i_start) begin
        busy <= 1'b1;
        cnt  <= i_delay;
      end else if (busy && !i_halt) begin
        if (cnt == 8'h00) begin
          busy   <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end

  // Result lines are only meaningful with done; otherwise they churn.
  assign o_err_serial  = o_done ? (i_mode == 2'h1) : junk[0];
  assign o_err_drive   = o_done ? (i_mode == 2'h2) : junk[1];
  assign o_err_code    = o_done ? i_code : junk;
  assign o_batch_err   = o_done ? i_batch : junk[2];
  assign o_batch_param = o_done ? (i_code ^ 16'h00ff) : ~junk;
endmodule : link_engine_model

// ### testbench.sv
// Self-checking bench for the drive request sequencer on channel 1.
// Assumes a shortened millisecond of MS cycles and a scan every SCAN.
module testbench
  import drive_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  localparam int SCAN = 8;
  localparam int SL = 5;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_scan = 1'b0, i_run = 1'b0;
  logic [SL-1:0] drive = '0, state_on = '1;
  logic [SL*3-1:0] kinds;
  logic [SL*16-1:0] steps;
  logic [7:0] delay = 8'h04;
  logic [1:0] mode = 2'h0;
  logic batch = 1'b0;
  logic [15:0] code = 16'h0000, bparam, ecode;
  logic done, eser, edrv, berr, start, halt, tod, busy, dflag;
  logic sfault, dfault, latch, bfault;
  logic [2:0] kind;
  logic [15:0] estep, scode, dcode, fstep, bpar;
  int cyc = 0, sc = 0, err_count = 0, comparisons = 0;

  link_engine_model LINK (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_start(start), .i_halt(halt), .i_delay(delay), .i_mode(mode),
    .i_batch(batch), .i_code(code), .o_done(done), .o_err_serial(eser),
    .o_err_drive(edrv), .o_err_code(ecode), .o_batch_err(berr),
    .o_batch_param(bparam));
  drive_link_request_sequencer #(.SLOTS(SL), .MS_CYCLES(MS),
    .CHANNEL(1'b0)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_scan(i_scan), .i_run(i_run), .i_drive(drive),
    .i_state_on(state_on), .i_req_kind(kinds), .i_req_step(steps),
    .i_xfer_done(done), .i_xfer_err_serial(eser),
    .i_xfer_err_drive(edrv), .i_xfer_err_code(ecode),
    .i_batch_err(berr), .i_batch_err_param(bparam),
    .o_xfer_start(start), .o_xfer_halt(halt), .o_xfer_kind(kind),
    .o_xfer_to_drive(tod), .o_exec_step(estep), .o_port_busy(busy),
    .o_done_pulse_flag(dflag), .o_serial_fault(sfault),
    .o_serial_fault_code(scode), .o_drive_fault(dfault),
    .o_drive_fault_latch(latch), .o_drive_fault_code(dcode),
    .o_fault_step(fstep), .o_batch_write_fault(bfault),
    .o_batch_fault_param(bpar));

  // Clock of 5 ns period.
  always #2.5 i_clk = ~i_clk;

  // Scan strobe, cycle count and the hang limit.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    sc <= (sc == SCAN - 1) ? 0 : sc + 1;
    i_scan <= (sc == SCAN - 1);
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(negedge i_clk);
      n++;
    end
    check(n < 600, 1'b1);
  endtask : wait_idle

  task automatic wait_start(input int s);
    int n;
    n = 0;
    @(negedge i_clk);
    while (start !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    check(n < 400, 1'b1);
    check(kind, 16'(s));
    check(tod, !(s == 0 || s == 2));
    check(estep, 16'h0100 + 16'(s));
    check(busy, 1'b1);
  endtask : wait_start

  // Judges one finished exchange, then lets its drive fall.
  task automatic finish(input int s, input logic [1:0] m, input logic b);
    int n;
    int w;
    n = 0;
    w = 0;
    wait_idle();
    check(sfault, m != 2'h0);
    check(dfault, m == 2'h2);
    if (m == 2'h1) check(scode, CODE_SERIAL_CH1);
    if (m == 2'h1) check(latch, 1'b0);
    if (m == 2'h2) check(scode, CODE_DRIVE_CH1);
    if (m == 2'h2) check(latch, 1'b1);
    if (m == 2'h2) check(dcode, code);
    if (m == 2'h2) check(fstep, 16'h0100 + 16'(s));
    check(bfault, b);
    if (b) check(bpar, code ^ 16'h00ff);
    while (dflag !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    while (dflag === 1'b1 && w < 40) begin
      @(negedge i_clk);
      w++;
    end
    check(16'(w), 16'(SCAN));
    @(posedge i_clk);
    drive[s] <= 1'b0;
    // Let a scan see the low drive, so a later rise of this slot counts.
    repeat (SCAN) @(posedge i_clk);
  endtask : finish

  task automatic one_req(input int s, input logic [1:0] m, input logic b);
    @(posedge i_clk);
    mode <= m;
    batch <= b;
    code <= 16'h00a0 + 16'(s);
    drive[s] <= 1'b1;
    wait_start(s);
    finish(s, m, b);
  endtask : one_req

  task automatic t_kinds();
    for (int s = 0; s < SL; s++) one_req(s, 2'h0, 1'b0);
    $display("test kinds done");
  endtask : t_kinds

  task automatic t_order();
    int t0;
    @(posedge i_clk);
    drive[3] <= 1'b1;
    drive[1] <= 1'b1;
    wait_start(1);
    wait_idle();
    t0 = cyc;
    wait_start(3);
    check(cyc - t0 >= 15 * MS && cyc - t0 <= 18 * MS, 1'b1);
    @(posedge i_clk);
    drive[1] <= 1'b0;
    finish(3, 2'h0, 1'b0);
    $display("test order done");
  endtask : t_order

  task automatic t_drop();
    logic seen;
    seen = 1'b0;
    @(posedge i_clk);
    drive[0] <= 1'b1;
    drive[2] <= 1'b1;
    wait_start(0);
    finish(0, 2'h0, 1'b0);
    drive[2] <= 1'b0;
    repeat (20 * MS) begin
      @(negedge i_clk);
      seen = seen | (start === 1'b1);
    end
    check(seen, 1'b0);
    $display("test drop done");
  endtask : t_drop

  task automatic t_repeat();
    @(posedge i_clk);
    drive[2] <= 1'b1;
    wait_start(2);
    wait_idle();
    wait_start(2);
    finish(2, 2'h0, 1'b0);
    $display("test repeat done");
  endtask : t_repeat

  task automatic t_errors();
    one_req(0, 2'h1, 1'b0);
    one_req(4, 2'h2, 1'b1);
    one_req(1, 2'h0, 1'b0);
    $display("test errors done");
  endtask : t_errors

  task automatic t_halt();
    logic bad;
    bad = 1'b0;
    @(posedge i_clk);
    delay <= 8'h3c;
    drive[1] <= 1'b1;
    wait_start(1);
    @(posedge i_clk);
    state_on[1] <= 1'b0;
    drive[4] <= 1'b1;
    repeat (2) @(negedge i_clk);
    repeat (40) begin
      @(negedge i_clk);
      bad = bad | (halt !== 1'b1) | (busy !== 1'b1) | (start === 1'b1);
    end
    check(bad, 1'b0);
    @(posedge i_clk);
    state_on[1] <= 1'b1;
    finish(1, 2'h0, 1'b0);
    wait_start(4);
    finish(4, 2'h0, 1'b0);
    delay <= 8'h04;
    $display("test halt done");
  endtask : t_halt

  task automatic t_run();
    check(latch, 1'b1);
    @(posedge i_clk);
    i_run <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_run <= 1'b1;
    repeat (2) @(negedge i_clk);
    check({sfault, dfault, latch, bfault}, 16'h0000);
    check(scode | dcode | fstep | bpar, 16'h0000);
    one_req(0, 2'h0, 1'b0);
    $display("test run done");
  endtask : t_run

  // Static request table, reset, then the scenarios in order.
  initial begin
    for (int i = 0; i < SL; i++) begin
      kinds[i*3+:3] = 3'(i);
      steps[i*16+:16] = 16'h0100 + 16'(i);
    end
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    i_run <= 1'b1;
    repeat (SCAN) @(posedge i_clk);
    t_kinds();
    t_order();
    t_drop();
    t_repeat();
    t_errors();
    t_halt();
    t_run();
    end_sim();
  end
endmodule : testbench
